//--- delay_stage.sv
module delay_stage (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic unit_tick,
  input wire logic din,
  input wire logic [14:0] on_delay,
  input wire logic [14:0] off_delay,
  output logic dout
);
  logic [14:0] cnt_reg;
  logic [14:0] lim;

  assign lim = din ? on_delay : off_delay;

  // Partial first unit: a change may land up to one unit early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 15'h0000;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_reg <= 15'h0000;
    end else if (lim == 15'h0000) begin
      dout <= din;
    end else if (unit_tick) begin
      if (cnt_reg + 15'h0001 >= lim) begin
        dout <= din;
        cnt_reg <= 15'h0000;
      end else begin
        cnt_reg <= cnt_reg + 15'h0001;
      end
    end
  end
endmodule : delay_stage

//--- switch_panel.sv
module switch_panel (
  input wire logic aclk,
  input wire logic [9:0] closed,
  input wire logic hold_on,
  output logic [9:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts land one clock after the operator moves them
  always_ff @(posedge aclk) begin
    pins <= closed | {7'h00, hold_on, 2'h0};
  end
endmodule : switch_panel

//--- tcd_monitor.sv
module tcd_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic forward_run,
  input wire logic reverse_run,
  input wire logic [9:0] input_state,
  input wire logic [31:0] freq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ud;
  assign ud = input_state[3] ^ input_state[4];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_runs_exclusive: assert property (
    !(forward_run && reverse_run)) else $error("both run outputs high");
  chk_fwd_cause: assert property (
    forward_run |-> $past(input_state[0]) || $past(input_state[2]))
    else $error("forward run without enable");
  chk_rev_cause: assert property (
    reverse_run |-> $past(input_state[1]) || $past(input_state[2]))
    else $error("reverse run without enable");
  chk_freq_cause: assert property (
    $changed(freq_out) |-> $past(ud) || $past(ud, 2))
    else $error("frequency moved without up or down");
  chk_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_r_answer: assert property (
    arvalid && arready |=> rvalid) else $error("read not answered");
  chk_b_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write not answered");
  chk_r_busy: assert property (
    rvalid |-> !arready) else $error("read taken while busy");
  cover property (forward_run);
  cover property (reverse_run);
  cover property (bvalid && bready && bresp == term_cmd_pkg::RESP_SLVERR);
endmodule : tcd_monitor

bind terminal_run_command_decoder tcd_monitor mon (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .forward_run,
  .reverse_run, .input_state, .freq_out);

//--- term_cmd_pkg.sv
// What this block does
// - Mode 1: input one enables running, input two selects direction.
// - Mode 1: A on B off forward, both on reverse, A off stop.
// - Mode 2: input three enables, input one forward, input two reverse.
// - Mode 2, hold on: button one press forward, button two reverse.
// - Mode 2: running state follows the latest button action.
// - Modes 2 and 3: hold button off stops at once.
// - Mode 3: input three enables, input one runs, input two direction.
// - Mode 3, hold on: button one on-edge starts running immediately.
// - Mode 3: direction switch off forward, on reverse.
// - Up/down terminals ramp frequency at set rate, 1..65535 milli-Hz/s.
// - Resolution value 1 scales the ramp rate by ten.
// - Each change on inputs one to five is delayed by its ON or OFF delay, 0 to 3000.0 s.
// - Delay stages on inputs one to five only; others pass through.
// - One decimal digit per input selects level; two words, units first.
// - Digit 0: tied to common return is inactive, open is active.
// - Digit 1: tied to common return is active, open is inactive.
// - Mode 0: only A forward, only B reverse, both or none stop.
// - Input states are filtered 0 to 1.000 s, default 0.010 s.
package term_cmd_pkg;
  localparam int N_IN = 10;
  localparam int N_DLY = 5;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_UNIT_MS = 100;
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] RATE_OFF = 8'h04;
  localparam logic [7:0] RES_OFF = 8'h08;
  localparam logic [7:0] FILT_OFF = 8'h0c;
  localparam logic [7:0] POL_LO_OFF = 8'h10;
  localparam logic [7:0] POL_HI_OFF = 8'h14;
  localparam logic [7:0] STAT_OFF = 8'h18;
  localparam logic [7:0] FREQ_OFF = 8'h1c;
  localparam logic [7:0] DLY_BASE = 8'h20;
  localparam logic [7:0] DLY_END = 8'h48;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] RATE_RST = 16'h03e8;
  localparam logic [15:0] RATE_MIN = 16'h0001;
  localparam logic [1:0] RES_RST = 2'h2;
  localparam logic [1:0] RES_COARSE = 2'h1;
  localparam logic [31:0] COARSE_MUL = 32'h0000000a;
  localparam logic [9:0] FILT_RST = 10'h00a;
  localparam logic [9:0] FILT_MAX = 10'h3e8;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [14:0] DLY_RST = 15'h0000;
  localparam logic [14:0] DLY_MAX = 15'h7530;
  localparam int STAT_FWD_BIT = 0;
  localparam int STAT_REV_BIT = 1;
  localparam int STAT_IN_LSB = 8;
  localparam int UP_IDX = 3;
  localparam int DOWN_IDX = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_TWO_1,
    MODE_TWO_2,
    MODE_THREE_1,
    MODE_THREE_2
  } cmd_mode_t;
endpackage : term_cmd_pkg

//--- terminal_run_command_decoder.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
module terminal_run_command_decoder #(
  parameter int MS_CYCLES = term_cmd_pkg::MS_CYCLES_DEF,
  parameter logic [31:0] FREQ_MAX = 32'h3b9aca00
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [9:0] terminal_in,
  output logic forward_run,
  output logic reverse_run,
  output logic [9:0] input_state,
  output logic [31:0] freq_out
);
  localparam int MS_W = $clog2(MS_CYCLES);

  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  function automatic logic [4:0] pol_bits(input logic [15:0] v);
    logic [15:0] d;
    logic [4:0] r;
    d = v;
    r = 5'h00;
    for (int k = 0; k < 5; k++) begin
      r[k] = ((d % 16'h000a) == 16'h0001);
      d = d / 16'h000a;
    end
    return r;
  endfunction : pol_bits

  function automatic logic addr_hit(input logic [7:0] a);
    return (a[1:0] == 2'h0) &&
      (a <= term_cmd_pkg::FREQ_OFF ||
       (a >= term_cmd_pkg::DLY_BASE && a < term_cmd_pkg::DLY_END));
  endfunction : addr_hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [1:0] mode_reg;
  logic [15:0] rate_reg;
  logic [1:0] res_reg;
  logic [9:0] filt_reg;
  logic [15:0] pol_lo_reg;
  logic [15:0] pol_hi_reg;
  logic [14:0] dly_reg [2*term_cmd_pkg::N_DLY];
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [3:0] widx;
  logic [31:0] wm;
  logic [31:0] rd_next;
  logic [3:0] ridx;

  assign do_write = !awready && !wready && !bvalid;
  assign widx = 4'((aw_addr_reg - term_cmd_pkg::DLY_BASE) >> 2);
  assign ridx = 4'((araddr - term_cmd_pkg::DLY_BASE) >> 2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= term_cmd_pkg::RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= addr_hit(aw_addr_reg) ? term_cmd_pkg::RESP_OKAY
                                       : term_cmd_pkg::RESP_SLVERR;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Word as it will stand after the byte-enable merge
  always_comb begin
    wm = 32'h00000000;
    unique case (aw_addr_reg)
      term_cmd_pkg::MODE_OFF: wm = {30'h0, mode_reg};
      term_cmd_pkg::RATE_OFF: wm = {16'h0, rate_reg};
      term_cmd_pkg::RES_OFF: wm = {30'h0, res_reg};
      term_cmd_pkg::FILT_OFF: wm = {22'h0, filt_reg};
      term_cmd_pkg::POL_LO_OFF: wm = {16'h0, pol_lo_reg};
      term_cmd_pkg::POL_HI_OFF: wm = {16'h0, pol_hi_reg};
      default: begin
        if (aw_addr_reg >= term_cmd_pkg::DLY_BASE &&
            addr_hit(aw_addr_reg)) begin
          wm = {17'h0, dly_reg[widx]};
        end
      end
    endcase
    wm = merge(wm, w_data_reg, w_strb_reg);
  end

  // Out-of-range filter and delay values clamp to their maximum; a rate below 1 becomes 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= term_cmd_pkg::MODE_RST;
      rate_reg <= term_cmd_pkg::RATE_RST;
      res_reg <= term_cmd_pkg::RES_RST;
      filt_reg <= term_cmd_pkg::FILT_RST;
      pol_lo_reg <= term_cmd_pkg::POL_RST;
      pol_hi_reg <= term_cmd_pkg::POL_RST;
      for (int i = 0; i < 2*term_cmd_pkg::N_DLY; i++) begin
        dly_reg[i] <= term_cmd_pkg::DLY_RST;
      end
    end else if (do_write) begin
      unique case (aw_addr_reg)
        term_cmd_pkg::MODE_OFF: mode_reg <= wm[1:0];
        term_cmd_pkg::RATE_OFF: begin
          rate_reg <= (wm[15:0] < term_cmd_pkg::RATE_MIN) ?
                      term_cmd_pkg::RATE_MIN : wm[15:0];
        end
        term_cmd_pkg::RES_OFF: res_reg <= wm[1:0];
        term_cmd_pkg::FILT_OFF: begin
          filt_reg <= (wm > 32'(term_cmd_pkg::FILT_MAX)) ?
                      term_cmd_pkg::FILT_MAX : wm[9:0];
        end
        term_cmd_pkg::POL_LO_OFF: pol_lo_reg <= wm[15:0];
        term_cmd_pkg::POL_HI_OFF: pol_hi_reg <= wm[15:0];
        default: begin
          if (aw_addr_reg >= term_cmd_pkg::DLY_BASE &&
              addr_hit(aw_addr_reg)) begin
            dly_reg[widx] <= (wm > 32'(term_cmd_pkg::DLY_MAX)) ?
                             term_cmd_pkg::DLY_MAX : wm[14:0];
          end
        end
      endcase
    end
  end

  // Timebases: 1 ms for filter and ramp, 0.1 s for delays
  logic [MS_W-1:0] ms_cnt_reg;
  logic ms_tick_reg;
  logic [6:0] unit_cnt_reg;
  logic unit_tick_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == MS_W'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= '0;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + MS_W'(1);
      ms_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_cnt_reg <= 7'h00;
      unit_tick_reg <= 1'b0;
    end else begin
      unit_tick_reg <= 1'b0;
      if (ms_tick_reg) begin
        if (unit_cnt_reg == 7'(term_cmd_pkg::DLY_UNIT_MS - 1)) begin
          unit_cnt_reg <= 7'h00;
          unit_tick_reg <= 1'b1;
        end else begin
          unit_cnt_reg <= unit_cnt_reg + 7'h01;
        end
      end
    end
  end

  // Input chain
  logic [9:0] pol_sel;
  logic [9:0] act_reg;
  logic [9:0] filt_state;
  logic [9:0] cond;

  assign pol_sel = {pol_bits(pol_hi_reg), pol_bits(pol_lo_reg)};

  // Pin level 1 means tied to common return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_reg <= 10'h000;
    end else begin
      act_reg <= pol_sel ^ ~terminal_in;
    end
  end

  for (genvar i = 0; i < term_cmd_pkg::N_IN; i++) begin : g_in
    logic [9:0] fcnt_reg;
    logic fst_reg;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fcnt_reg <= 10'h000;
        fst_reg <= 1'b0;
      end else if (act_reg[i] == fst_reg) begin
        fcnt_reg <= 10'h000;
      end else if (filt_reg == 10'h000) begin
        fst_reg <= act_reg[i];
      end else if (ms_tick_reg) begin
        if (fcnt_reg + 10'h001 >= filt_reg) begin
          fst_reg <= act_reg[i];
          fcnt_reg <= 10'h000;
        end else begin
          fcnt_reg <= fcnt_reg + 10'h001;
        end
      end
    end

    assign filt_state[i] = fst_reg;

    if (i < term_cmd_pkg::N_DLY) begin : g_dly
      delay_stage u_dly (
        .aclk(aclk),
        .aresetn(aresetn),
        .unit_tick(unit_tick_reg),
        .din(filt_state[i]),
        .on_delay(dly_reg[2*i]),
        .off_delay(dly_reg[2*i+1]),
        .dout(cond[i])
      );
    end else begin : g_pass
      assign cond[i] = filt_state[i];
    end
  end

  assign input_state = cond;

  // Command decoder
  term_cmd_pkg::cmd_mode_t mode;
  logic [1:0] prev_reg;
  logic rise1;
  logic rise2;
  logic latch_reg;
  logic run3;

  assign mode = term_cmd_pkg::cmd_mode_t'(mode_reg);
  assign rise1 = cond[0] & ~prev_reg[0];
  assign rise2 = cond[1] & ~prev_reg[1];
  assign run3 = latch_reg | (rise1 & cond[2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 2'h0;
    end else begin
      prev_reg <= cond[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= 1'b0;
    end else if (mode != term_cmd_pkg::MODE_THREE_2 || !cond[2]) begin
      latch_reg <= 1'b0;
    end else if (rise1) begin
      latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      forward_run <= 1'b0;
      reverse_run <= 1'b0;
    end else begin
      unique case (mode)
        term_cmd_pkg::MODE_TWO_1: begin
          forward_run <= cond[0] & ~cond[1];
          reverse_run <= ~cond[0] & cond[1];
        end
        term_cmd_pkg::MODE_TWO_2: begin
          forward_run <= cond[0] & ~cond[1];
          reverse_run <= cond[0] & cond[1];
        end
        term_cmd_pkg::MODE_THREE_1: begin
          // Simultaneous presses keep the present state
          if (!cond[2]) begin
            forward_run <= 1'b0;
            reverse_run <= 1'b0;
          end else if (rise1 && !rise2) begin
            forward_run <= 1'b1;
            reverse_run <= 1'b0;
          end else if (rise2 && !rise1) begin
            forward_run <= 1'b0;
            reverse_run <= 1'b1;
          end
        end
        term_cmd_pkg::MODE_THREE_2: begin
          forward_run <= cond[2] & run3 & ~cond[1];
          reverse_run <= cond[2] & run3 & cond[1];
        end
      endcase
    end
  end

  // Frequency ramp in micro-Hz; fine rate unit adds 1 per ms per LSB
  logic [31:0] step;
  logic up;
  logic down;

  assign step = (res_reg == term_cmd_pkg::RES_COARSE) ?
                32'(rate_reg) * term_cmd_pkg::COARSE_MUL :
                32'(rate_reg);
  assign up = cond[term_cmd_pkg::UP_IDX] & ~cond[term_cmd_pkg::DOWN_IDX];
  assign down = cond[term_cmd_pkg::DOWN_IDX] & ~cond[term_cmd_pkg::UP_IDX];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_out <= 32'h00000000;
    end else if (ms_tick_reg && up) begin
      freq_out <= (FREQ_MAX - freq_out < step) ? FREQ_MAX
                  : freq_out + step;
    end else if (ms_tick_reg && down) begin
      freq_out <= (freq_out < step) ? 32'h00000000
                  : freq_out - step;
    end
  end

  // Register read
  always_comb begin
    rd_next = 32'h00000000;
    unique case (araddr)
      term_cmd_pkg::MODE_OFF: rd_next = {30'h0, mode_reg};
      term_cmd_pkg::RATE_OFF: rd_next = {16'h0, rate_reg};
      term_cmd_pkg::RES_OFF: rd_next = {30'h0, res_reg};
      term_cmd_pkg::FILT_OFF: rd_next = {22'h0, filt_reg};
      term_cmd_pkg::POL_LO_OFF: rd_next = {16'h0, pol_lo_reg};
      term_cmd_pkg::POL_HI_OFF: rd_next = {16'h0, pol_hi_reg};
      term_cmd_pkg::STAT_OFF: begin
        rd_next[term_cmd_pkg::STAT_FWD_BIT] = forward_run;
        rd_next[term_cmd_pkg::STAT_REV_BIT] = reverse_run;
        rd_next[term_cmd_pkg::STAT_IN_LSB +: 10] = cond;
      end
      term_cmd_pkg::FREQ_OFF: rd_next = freq_out;
      default: begin
        if (addr_hit(araddr)) begin
          rd_next = {17'h0, dly_reg[ridx]};
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= term_cmd_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_next;
      rresp <= addr_hit(araddr) ? term_cmd_pkg::RESP_OKAY
                                : term_cmd_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : terminal_run_command_decoder

//--- terminal_run_command_decoder_tb_top.sv
module terminal_run_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic hold_on = 1'b0;
  logic [9:0] closed = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, forward_run, reverse_run;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, freq_out;
  logic [9:0] pins, input_state;
  int fails = 0;
  int n_tests = 0;
  // {mode, pins three to one, forward, reverse}
  logic [6:0] rows [8] = '{7'h06, 7'h09, 7'h0c, 7'h00,
                           7'h26, 7'h2d, 7'h20, 7'h28};

  always #50 aclk = ~aclk;

  switch_panel panel (.aclk, .closed, .hold_on, .pins);

  terminal_run_command_decoder #(.MS_CYCLES(10)) DUT (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .terminal_in(pins), .forward_run, .reverse_run, .input_state,
    .freq_out);

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    resp = bresp;
    bready <= 1'b0;
    chk("bvalid", {31'h0, bvalid}, 32'h1);
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk("rdata", rdata, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask : rd_chk

  // Settles through panel, polarity, filter, delay and decoder
  task automatic drive(input logic [9:0] c, input logic h);
    @(posedge aclk);
    closed <= c;
    hold_on <= h;
    repeat (8) @(posedge aclk);
  endtask : drive

  task automatic runs(input logic f, input logic r);
    chk("fwd", {31'h0, forward_run}, {31'h0, f});
    chk("rev", {31'h0, reverse_run}, {31'h0, r});
  endtask : runs

  // Ticks may land anywhere, so measure between two steps
  task automatic step_chk(input logic [31:0] e);
    logic [31:0] a;
    int n;
    for (int k = 0; k < 2; k++) begin
      a = freq_out;
      n = 0;
      while (freq_out === a && n < 100) begin
        @(posedge aclk);
        n++;
      end
    end
    chk("freq", freq_out - a, e);
  endtask : step_chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge aclk);
    fails++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(term_cmd_pkg::MODE_OFF, 32'h0, 2'h0);
    rd_chk(term_cmd_pkg::RATE_OFF, 32'h3e8, 2'h0);
    rd_chk(term_cmd_pkg::RES_OFF, 32'h2, 2'h0);
    rd_chk(term_cmd_pkg::FILT_OFF, 32'ha, 2'h0);
    rd_chk(term_cmd_pkg::POL_LO_OFF, 32'h0, 2'h0);
    rd_chk(term_cmd_pkg::POL_HI_OFF, 32'h0, 2'h0);
    rd_chk(8'h4c, 32'h0, term_cmd_pkg::RESP_SLVERR);
    axi_wr(8'h4c, 32'h1);
    chk("bresp", {30'h0, resp}, {30'h0, term_cmd_pkg::RESP_SLVERR});
    $display("test registers done");
    axi_wr(term_cmd_pkg::FILT_OFF, 32'h0);
    axi_wr(term_cmd_pkg::POL_LO_OFF, 32'h2b67);
    axi_wr(term_cmd_pkg::POL_HI_OFF, 32'h2b67);
    rd_chk(term_cmd_pkg::POL_LO_OFF, 32'h2b67, 2'h0);
    for (int i = 0; i < 8; i++) begin
      axi_wr(term_cmd_pkg::MODE_OFF, {30'h0, rows[i][6:5]});
      drive({7'h00, rows[i][4:2]}, 1'b0);
      runs(rows[i][1], rows[i][0]);
      chk("state", {22'h0, input_state}, {22'h0, closed});
    end
    $display("test table done");
    axi_wr(term_cmd_pkg::MODE_OFF, 32'h2);
    drive(10'h000, 1'b1);
    drive(10'h001, 1'b1);
    drive(10'h000, 1'b1);
    runs(1'b1, 1'b0);
    drive(10'h002, 1'b1);
    drive(10'h000, 1'b1);
    runs(1'b0, 1'b1);
    drive(10'h000, 1'b0);
    runs(1'b0, 1'b0);
    axi_wr(term_cmd_pkg::MODE_OFF, 32'h3);
    drive(10'h002, 1'b1);
    runs(1'b0, 1'b0);
    drive(10'h003, 1'b1);
    runs(1'b0, 1'b1);
    rd_chk(term_cmd_pkg::STAT_OFF, 32'h00000702, 2'h0);
    drive(10'h000, 1'b1);
    runs(1'b1, 1'b0);
    drive(10'h000, 1'b0);
    runs(1'b0, 1'b0);
    $display("test three-line done");
    axi_wr(term_cmd_pkg::POL_LO_OFF, 32'h2b66);
    // Polarity, filter and delay stages each add a cycle
    repeat (4) @(posedge aclk);
    chk("state0", {31'h0, input_state[0]}, 32'h1);
    chk("state1", {31'h0, input_state[1]}, 32'h0);
    drive(10'h001, 1'b0);
    chk("state0", {31'h0, input_state[0]}, 32'h0);
    axi_wr(term_cmd_pkg::POL_LO_OFF, 32'h2b67);
    drive(10'h000, 1'b0);
    axi_wr(term_cmd_pkg::DLY_BASE, 32'h3);
    drive(10'h021, 1'b0);
    repeat (1500) @(posedge aclk);
    chk("state0", {31'h0, input_state[0]}, 32'h0);
    chk("state5", {31'h0, input_state[5]}, 32'h1);
    drive(10'h000, 1'b0);
    repeat (2000) @(posedge aclk);
    chk("state0", {31'h0, input_state[0]}, 32'h0);
    drive(10'h001, 1'b0);
    repeat (1000) @(posedge aclk);
    chk("state0", {31'h0, input_state[0]}, 32'h0);
    repeat (2200) @(posedge aclk);
    chk("state0", {31'h0, input_state[0]}, 32'h1);
    drive(10'h000, 1'b0);
    $display("test delay done");
    axi_wr(term_cmd_pkg::RATE_OFF, 32'h5);
    drive(10'h008, 1'b0);
    step_chk(32'h5);
    axi_wr(term_cmd_pkg::RES_OFF, 32'h1);
    step_chk(32'h32);
    repeat (200) @(posedge aclk);
    drive(10'h010, 1'b0);
    step_chk(32'hffffffce);
    drive(10'h000, 1'b0);
    $display("test ramp done");
    axi_wr(term_cmd_pkg::DLY_BASE + 8'h04, 32'h0000ffff);
    rd_chk(term_cmd_pkg::DLY_BASE + 8'h04, 32'h00007530, 2'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("freq", freq_out, 32'h0);
    chk("state", {22'h0, input_state}, 32'h0);
    rd_chk(term_cmd_pkg::POL_LO_OFF, 32'h0, 2'h0);
    // Default filter holds open pins back for ten ms ticks
    repeat (60) @(posedge aclk);
    chk("state", {22'h0, input_state}, 32'h0);
    repeat (100) @(posedge aclk);
    chk("state", {22'h0, input_state}, 32'h3ff);
    $display("test reset done");
    final_report();
  end
endmodule : terminal_run_command_decoder_tb_top
